// ===== design/usbsie_regs.vh
// Purpose: Constants for the USB engine control block
// Assumes: Avalon-MM slave, 32-bit data, byte addresses
// Notes: Control and configuration registers are one word each
// How it works
// - Control register shows a flag when both data lines sit at SE0.
// - Setting enable starts the engine and clears all pointer indicators.
// - Enable turns on pull-ups when pull-up enable and configured are set, acting as soft attach and detach.
// - Pointer reset in ping-pong modes forces all pointers to even buffer.
// - Pointer reset ignored without ping-pong; never self-cleared by hardware.
// - SETUP token sets packet hold flag, stopping all packet traffic.
// - Packet hold flag ignores writes of one; writing zero resumes traffic.
// - Pending events stay available while packets are held.
// - Resume bit drives remote-wake signalling; firmware holds it 10 ms.
// - Suspend bit lowers power and gates the engine clock off.
// - In suspend device stays attached, transceiver outputs idle unless resume bit is set.
// - Configuration holds eye pattern bit starting test pattern output.
// - Transceiver on with enable; full speed when select bit is one.
// - Pull-ups on only with pull-up enable, module enable, configured.
// - Buffer scheme field selects the ping-pong arrangement.
// - Eye test repeats J-K forever, starting with K at full speed.
`ifndef USBSIE_REGS_VH
`define USBSIE_REGS_VH
`define USBSIE_CTRL_ADDR 4'h0
`define USBSIE_CFG_ADDR 4'h4
`define USBSIE_STAT_ADDR 4'h8
`define USBSIE_CTRL_PPRST 1
`define USBSIE_CTRL_SE0 5
`define USBSIE_CTRL_PKTHOLD 4
`define USBSIE_CTRL_ENABLE 3
`define USBSIE_CTRL_RESUME 2
`define USBSIE_CTRL_SUSPEND 0
`define USBSIE_CTRL_RESET 8'h00
`define USBSIE_CFG_EYE 7
`define USBSIE_CFG_PULLUP 4
`define USBSIE_CFG_FS 2
`define USBSIE_CFG_SCHEME_LO 0
`define USBSIE_CFG_SCHEME_HI 1
`define USBSIE_CFG_RESET 8'h00
`define USBSIE_SCHEME_NONE 2'h0
`define USBSIE_NUM_BD 16
`endif

// ===== design/usbsie_ctrl.v
// Purpose: Control and configuration logic of a USB device engine
// Assumes: Single 10 MHz clock, async active-low reset, Avalon-MM slave
// Notes: Serial engine, status FIFO and descriptor RAM live elsewhere
`timescale 1ns/1ps
`include "usbsie_regs.vh"
module usbsie_ctrl (
  input wire clock_in, // System clock
  input wire rst_b_in, // Async reset, active low
  input wire [3:0] avs_address_in, // Byte address
  input wire avs_read_in, // Read request
  input wire avs_write_in, // Write request
  input wire [31:0] avs_writedata_in, // Write data
  input wire [3:0] avs_byteenable_in, // Byte enables
  output reg [31:0] avs_readdata_out, // Read data
  output wire avs_waitrequest_out, // Wait request
  input wire dp_in, // Sampled D+ line
  input wire dm_in, // Sampled D- line
  input wire setup_token_in, // Pulse: SETUP token decoded
  input wire configured_in, // Module configured for use
  output reg xcvr_en_out, // Transceiver enable
  output reg xcvr_fs_out, // Full speed select
  output reg pullup_out, // Internal pull-up on
  output reg sie_clk_en_out, // Engine clock gate
  output reg low_power_out, // Low-power mode
  output reg packet_enable_out, // Packet traffic allowed
  output reg resume_drive_out, // Drive resume K state
  output reg eye_active_out, // Eye test running
  output reg tx_dp_out, // Transmit D+ level
  output reg tx_dm_out, // Transmit D- level
  output reg tx_oe_out, // Transmit output enable
  output reg [1:0] buffer_scheme_out, // Ping-pong arrangement
  output reg [15:0] pointer_indicator_out // Per-descriptor odd pointer
);
  reg [7:0] ctrl;
  reg [7:0] cfg;
  reg se0_flag;
  reg ack;
  reg eye_phase;
  wire wr_ctrl;
  wire wr_cfg;
  wire enable;
  wire suspend;
  wire pp_reset;
  wire enable_rise;
  wire [7:0] ctrl_read;

  // One wait state per access gives a registered answer
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
  assign wr_ctrl = avs_write_in & ack & avs_byteenable_in[0] &
    (avs_address_in == `USBSIE_CTRL_ADDR);
  assign wr_cfg = avs_write_in & ack & avs_byteenable_in[0] &
    (avs_address_in == `USBSIE_CFG_ADDR);
  assign enable = ctrl[`USBSIE_CTRL_ENABLE];
  assign suspend = ctrl[`USBSIE_CTRL_SUSPEND];
  assign pp_reset = ctrl[`USBSIE_CTRL_PPRST];
  assign enable_rise = wr_ctrl & avs_writedata_in[`USBSIE_CTRL_ENABLE] &
    ~enable;
  assign ctrl_read = {2'h0, se0_flag, ctrl[4:0]};

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_in | avs_write_in) & ~ack;
    end
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in & ~ack) begin
      case (avs_address_in)
        `USBSIE_CTRL_ADDR: avs_readdata_out <= {24'h000000, ctrl_read};
        `USBSIE_CFG_ADDR: avs_readdata_out <= {24'h000000, cfg};
        `USBSIE_STAT_ADDR: avs_readdata_out <= {16'h0000,
          pointer_indicator_out};
        default: avs_readdata_out <= 32'h00000000;
      endcase
    end
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      se0_flag <= 1'b0;
    end else begin
      se0_flag <= ~dp_in & ~dm_in;
    end
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl <= `USBSIE_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl[`USBSIE_CTRL_ENABLE] <= avs_writedata_in[`USBSIE_CTRL_ENABLE];
        ctrl[`USBSIE_CTRL_RESUME] <= avs_writedata_in[`USBSIE_CTRL_RESUME];
        ctrl[`USBSIE_CTRL_SUSPEND] <= avs_writedata_in[`USBSIE_CTRL_SUSPEND];
        // Hardware never clears it; only firmware does
        ctrl[`USBSIE_CTRL_PPRST] <= avs_writedata_in[`USBSIE_CTRL_PPRST];
      end
      // Set wins over a clearing write in the same cycle
      if (setup_token_in & enable) begin
        ctrl[`USBSIE_CTRL_PKTHOLD] <= 1'b1;
      end else if (wr_ctrl & ~avs_writedata_in[`USBSIE_CTRL_PKTHOLD]) begin
        ctrl[`USBSIE_CTRL_PKTHOLD] <= 1'b0;
      end
    end
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg <= `USBSIE_CFG_RESET;
    end else if (wr_cfg) begin
      cfg <= avs_writedata_in[7:0] & 8'h97;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `USBSIE_NUM_BD; i = i + 1) begin : g_ptr
      always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          pointer_indicator_out[i] <= 1'b0;
        end else if (enable_rise) begin
          pointer_indicator_out[i] <= 1'b0;
        end else if (pp_reset & (buffer_scheme_out != `USBSIE_SCHEME_NONE)) begin
          pointer_indicator_out[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Eye phase starts at K; K is D- high at full speed
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      eye_phase <= 1'b0;
    end else if (enable & cfg[`USBSIE_CFG_EYE] & ~suspend) begin
      eye_phase <= ~eye_phase;
    end else begin
      eye_phase <= 1'b0;
    end
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      xcvr_en_out <= 1'b0;
      xcvr_fs_out <= 1'b0;
      pullup_out <= 1'b0;
      sie_clk_en_out <= 1'b0;
      low_power_out <= 1'b0;
      packet_enable_out <= 1'b0;
      resume_drive_out <= 1'b0;
      eye_active_out <= 1'b0;
      tx_dp_out <= 1'b0;
      tx_dm_out <= 1'b0;
      tx_oe_out <= 1'b0;
      buffer_scheme_out <= 2'h0;
    end else begin
      xcvr_en_out <= enable;
      xcvr_fs_out <= cfg[`USBSIE_CFG_FS];
      // Pull-up stays during suspend so the device remains attached
      pullup_out <= enable & cfg[`USBSIE_CFG_PULLUP] & configured_in;
      sie_clk_en_out <= enable & ~suspend;
      low_power_out <= suspend;
      // Held packets leave status FIFO entries untouched
      packet_enable_out <= enable & ~ctrl[`USBSIE_CTRL_PKTHOLD] &
        ~suspend;
      buffer_scheme_out <= cfg[`USBSIE_CFG_SCHEME_HI:`USBSIE_CFG_SCHEME_LO];
      resume_drive_out <= enable & ctrl[`USBSIE_CTRL_RESUME];
      eye_active_out <= enable & cfg[`USBSIE_CFG_EYE] & ~suspend;
      if (!enable | (suspend & ~ctrl[`USBSIE_CTRL_RESUME])) begin
        tx_oe_out <= 1'b0;
        tx_dp_out <= 1'b0;
        tx_dm_out <= 1'b0;
      end else if (ctrl[`USBSIE_CTRL_RESUME]) begin
        // K state: opposite of idle J for the selected speed
        tx_oe_out <= 1'b1;
        tx_dp_out <= ~cfg[`USBSIE_CFG_FS];
        tx_dm_out <= cfg[`USBSIE_CFG_FS];
      end else if (cfg[`USBSIE_CFG_EYE]) begin
        tx_oe_out <= 1'b1;
        tx_dp_out <= cfg[`USBSIE_CFG_FS] ? eye_phase : ~eye_phase;
        tx_dm_out <= cfg[`USBSIE_CFG_FS] ? ~eye_phase : eye_phase;
      end else begin
        tx_oe_out <= 1'b0;
        tx_dp_out <= 1'b0;
        tx_dm_out <= 1'b0;
      end
    end
  end
endmodule

// ===== tb/usbsie_checker.sv
// Purpose: Port assertions for the USB engine control block
// Assumes: One clock, async active-low reset
// Notes: Registered outputs share one lag, so they are compared directly
`timescale 1ns/1ps
module usbsie_checker (
  input wire clock_in, // Clock
  input wire rst_b_in, // Reset
  input wire avs_read_in, // Read
  input wire avs_write_in, // Write
  input wire avs_waitrequest_out, // Wait
  input wire setup_token_in, // SETUP
  input wire xcvr_en_out, // Xcvr on
  input wire pullup_out, // Pull-up
  input wire sie_clk_en_out, // Clock gate
  input wire low_power_out, // Suspend
  input wire packet_enable_out, // Traffic
  input wire resume_drive_out, // Resume
  input wire eye_active_out, // Eye
  input wire tx_dp_out, // D+
  input wire tx_dm_out, // D-
  input wire tx_oe_out // Drive
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_req; (avs_read_in || avs_write_in) && avs_waitrequest_out; endsequence
  property p_wait; s_req |=> !avs_waitrequest_out; endproperty
  a_wait: assert property (p_wait) else $error("wait state not one cycle");
  property p_pull; pullup_out |-> xcvr_en_out; endproperty
  a_pull: assert property (p_pull) else $error("pull-up without enable");
  property p_clk; sie_clk_en_out == (xcvr_en_out && !low_power_out); endproperty
  a_clk: assert property (p_clk) else $error("clock gate wrong");
  property p_idle; low_power_out && !resume_drive_out |-> !tx_oe_out; endproperty
  a_idle: assert property (p_idle) else $error("driving in suspend");
  property p_hold; setup_token_in && xcvr_en_out |-> ##2 !packet_enable_out;
  endproperty
  a_hold: assert property (p_hold) else $error("SETUP did not hold");
  property p_res; resume_drive_out [*2] |-> tx_oe_out && tx_dp_out != tx_dm_out;
  endproperty
  a_res: assert property (p_res) else $error("no resume K");
  property p_eye; (eye_active_out && !resume_drive_out) [*3] |-> $changed(tx_dp_out);
  endproperty
  a_eye: assert property (p_eye) else $error("eye not toggling");
  property p_off; $fell(xcvr_en_out) |-> !pullup_out && !packet_enable_out;
  endproperty
  a_off: assert property (p_off) else $error("still attached");
endmodule
bind usbsie_ctrl usbsie_checker usbsie_checker_i (.*);

// ===== tb/usbsie_host.sv
// Purpose: Host side model: bus line levels and SETUP token pulses
// Assumes: Full-speed idle is J (D+ high)
// Notes: Outputs change only at clock edges
`timescale 1ns/1ps
module usbsie_host (
  input wire clock_in, // Clock
  input wire se0_in, // Request SE0 reset
  input wire setup_in, // Request one SETUP token
  output logic dp_out = 1'b1, // D+
  output logic dm_out = 1'b0, // D-
  output logic setup_token_out = 1'b0 // SETUP pulse
);
  always @(posedge clock_in) begin
    dp_out <= !se0_in;
    dm_out <= 1'b0;
    setup_token_out <= setup_in;
  end
endmodule

// ===== tb/tb.sv
// Purpose: Self-checking bench for the USB engine control block
// Assumes: Host model supplies bus lines and SETUP pulses
// Notes: Outputs lag their register by one clock, hence the settle
`timescale 1ns/1ps
module tb;
  logic clock_in = 0, rst_b_in = 0, avs_read_in = 0, avs_write_in = 0;
  logic [3:0] avs_address_in = 0, avs_byteenable_in = 4'hf;
  logic [31:0] avs_writedata_in = 0, q;
  logic configured_in = 0, se0 = 0, setup_req = 0;
  wire dp_in, dm_in, setup_token_in, avs_waitrequest_out, xcvr_en_out;
  wire xcvr_fs_out, pullup_out, sie_clk_en_out, low_power_out, tx_oe_out;
  wire packet_enable_out, resume_drive_out, eye_active_out, tx_dp_out, tx_dm_out;
  wire [31:0] avs_readdata_out;
  wire [1:0] buffer_scheme_out;
  wire [15:0] pointer_indicator_out;
  int miscompares = 0, cmp_count = 0;
  usbsie_ctrl usbsie_ctrl_i (.*);
  usbsie_host usbsie_host_i (.clock_in(clock_in), .se0_in(se0),
    .setup_in(setup_req), .dp_out(dp_in), .dm_out(dm_in),
    .setup_token_out(setup_token_in));
  always #50 clock_in = !clock_in;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    repeat (2) @(posedge clock_in);
  endtask
  task t_setup;
    bus(0, 4'h0, 0); chk(q, 0);
    bus(0, 4'hc, 0); chk(q, 0);
    // Write configuration before enabling; configured_in raised only after; supply assumed good
    bus(1, 4'h4, 32'h15);
    bus(1, 4'h0, 32'h0a);
    chk(pullup_out, 0);
    configured_in <= 1'b1;
    chk({xcvr_en_out, xcvr_fs_out, buffer_scheme_out}, 4'hd);
    bus(0, 4'h8, 0); chk(q, 0);
    chk(pullup_out, 1);
    bus(0, 4'h0, 0); chk(q[1], 1);
  endtask
  task t_hold;
    setup_req <= 1'b1;
    @(posedge clock_in);
    setup_req <= 1'b0;
    repeat (4) @(posedge clock_in);
    chk(packet_enable_out, 0);
    bus(1, 4'h0, 32'h18); bus(0, 4'h0, 0); chk(q[4], 1);
    bus(1, 4'h0, 32'h08); chk(packet_enable_out, 1);
  endtask
  task t_bus_states;
    se0 <= 1'b1;
    // Host line change and the flag register each take one edge
    repeat (2) @(posedge clock_in);
    bus(0, 4'h0, 0); chk(q[5], 1);
    se0 <= 1'b0;
    bus(1, 4'h0, 32'h0c); chk({tx_oe_out, tx_dp_out, tx_dm_out}, 3'h5);
    // Bus taken as idle here before suspend is set
    bus(1, 4'h0, 32'h09);
    chk({sie_clk_en_out, low_power_out, pullup_out,
      tx_oe_out}, 4'h6);
    bus(1, 4'h4, 32'h95); bus(1, 4'h0, 32'h08); chk(eye_active_out, 1);
    q = tx_dp_out;
    @(posedge clock_in);
    chk(tx_dp_out, !q[0]);
    bus(1, 4'h0, 0); chk({xcvr_en_out, pullup_out}, 0);
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock_in);
    rst_b_in <= 1'b1;
    t_setup; t_hold; t_bus_states;
    final_report;
  end
  initial begin
    repeat (2000) @(posedge clock_in);
    miscompares++;
    final_report;
  end
endmodule
